//--- verilog/usm_status_regs.sv
// Line status, modem status, scratch and divisor registers of the port
`timescale 1ns/100ps
// Functional notes
// R1: Holding-empty sets when character reaches shifter
// R2: Holding write clears holding-empty outside FIFO mode
// R3: FIFO mode: holding-empty follows transmit FIFO empty
// R4: Holding-empty interrupt only when its enable set
// R5: Transmitter-empty when holding and shift both empty
// R6: FIFO error stays zero outside FIFO mode
// R7: FIFO error tracks receive errors, read-clear
// R8: Change flags for CTS, DSR, carrier detect
// R9: Ring flag only on ring input rising
// R10: Reading modem status clears all change flags
// R11: Any change flag raises modem status interrupt
// R12: Current bits show inverted modem inputs normally; the code holds them at zero outside loopback
// R13: Loopback returns modem control bits as status
// R14: No modem pins; current bits loopback-only
// R15: Scratch byte read/write, affects nothing
// R16: Divisor write reloads counter; output 16x baud
// R17: Divisor 0,1,2 special; else low two counts
// R18: Source bit and select choose baud clock
// R19: Software sets divisor access bit for divisors
// R20: Both ports share contents and read side effects
module usm_status_regs
  import usm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic nsio_rst_i,
  input wire logic power_vcc_i,
  input wire logic [usm_pkg::ADDR_W-1:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  output logic [7:0] host_rdata_o,
  input wire logic [usm_pkg::ADDR_W-1:0] ec_addr_i,
  input wire logic [7:0] ec_wdata_i,
  input wire logic ec_wr_i,
  input wire logic ec_rd_i,
  output logic [7:0] ec_rdata_o,
  input wire logic fifo_mode_i,
  input wire logic tx_take_i,
  input wire logic tx_shift_busy_i,
  input wire logic tx_fifo_empty_i,
  input wire logic rx_fifo_has_error_i,
  input wire logic external_clock_source_i,
  input wire logic src_slow_i,
  input wire logic src_fast_i,
  input wire logic src_ext_i,
  output logic [7:0] tx_holding_register_o,
  output logic tx_hold_valid_o,
  output logic tx_push_o,
  output logic tx_hold_empty_flag_o,
  output logic tx_all_empty_flag_o,
  output logic tx_hold_empty_flag_irq_o,
  output logic modem_irq_o,
  output logic loopback_o,
  output logic baud16_o
);
  typedef struct packed {
    logic [7:0] tx_holding_register;
    logic tx_hold_empty_flag;
    logic fifo_err;
    logic divisor_access_bit;
    logic ier_tx_hold_empty_flag;
    logic ier_ms;
    logic [4:0] modem_control_register;
    logic [7:0] scratch_byte;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic tx_push;
    logic [7:0] host_rdata;
    logic [7:0] ec_rdata;
  } usm_regs_s;

  usm_regs_s q;
  usm_regs_s next_q;
  logic rst_n;
  logic wr;
  logic [ADDR_W-1:0] waddr;
  logic [7:0] wdata;
  logic thr_wr;
  logic div_wr;
  logic lsr_rd;
  logic msr_rd;
  logic tx_all_empty_flag;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic [15:0] divisor;

  // The runtime registers follow the I/O reset when powered from main supply
  assign rst_n = power_vcc_i ? nsio_rst_i : nrst_i;

  // The controller port wins a same-cycle write; both see one register set
  assign wr = host_wr_i | ec_wr_i; // [R20]
  assign waddr = ec_wr_i ? ec_addr_i : host_addr_i;
  assign wdata = ec_wr_i ? ec_wdata_i : host_wdata_i;
  // Divisor bytes are only reachable with the access bit set [R19]
  assign thr_wr = wr & (waddr == OFS_DATA) & ~q.divisor_access_bit;
  assign div_wr = wr & q.divisor_access_bit & ((waddr == OFS_DATA) | (waddr == OFS_IER));
  // A read from either port clears the shared flags [R20]
  assign lsr_rd = (host_rd_i & (host_addr_i == OFS_LSR))
    | (ec_rd_i & (ec_addr_i == OFS_LSR));
  assign msr_rd = (host_rd_i & (host_addr_i == OFS_MSR))
    | (ec_rd_i & (ec_addr_i == OFS_MSR));

  assign tx_all_empty_flag = q.tx_hold_empty_flag & ~tx_shift_busy_i; // [R5]
  // Top bit of the high byte is the clock select, not a divisor bit
  assign divisor = {1'b0, q.div_hi[DIVH_CLKSEL-1:0], q.div_lo};

  always_comb
  begin
    lsr_val = RST_BYTE;
    lsr_val[LSR_TX_HOLD_EMPTY_FLAG] = q.tx_hold_empty_flag;
    lsr_val[LSR_TX_ALL_EMPTY_FLAG] = tx_all_empty_flag;
    lsr_val[LSR_FERR] = q.fifo_err;
  end

  function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = RST_BYTE;
    unique case (a)
      OFS_DATA: v = q.divisor_access_bit ? q.div_lo : RST_BYTE;
      OFS_IER:
      begin
        if (q.divisor_access_bit)
          v = q.div_hi;
        else
        begin
          v[IER_TX_HOLD_EMPTY_FLAG] = q.ier_tx_hold_empty_flag;
          v[IER_MS] = q.ier_ms;
        end
      end
      OFS_FCR: v = RST_BYTE;
      OFS_LCR: v[LCR_DIVISOR_ACCESS_BIT] = q.divisor_access_bit;
      OFS_MCR: v[MCR_LOOP:0] = q.modem_control_register;
      OFS_LSR: v = lsr_val;
      OFS_MSR: v = msr_val;
      OFS_SCR: v = q.scratch_byte; // [R15]
    endcase
    return v;
  endfunction : read_mux

  always_comb
  begin
    next_q = q;
    next_q.tx_push = 1'b0;
    if (wr)
    begin
      unique case (waddr)
        OFS_DATA:
        begin
          if (q.divisor_access_bit)
            next_q.div_lo = wdata;
          else
            next_q.tx_holding_register = wdata;
        end
        OFS_IER:
        begin
          if (q.divisor_access_bit)
            next_q.div_hi = wdata;
          else
          begin
            next_q.ier_tx_hold_empty_flag = wdata[IER_TX_HOLD_EMPTY_FLAG];
            next_q.ier_ms = wdata[IER_MS];
          end
        end
        OFS_LCR: next_q.divisor_access_bit = wdata[LCR_DIVISOR_ACCESS_BIT];
        OFS_MCR: next_q.modem_control_register = wdata[MCR_LOOP:0];
        OFS_SCR: next_q.scratch_byte = wdata; // [R15]
        OFS_FCR, OFS_LSR, OFS_MSR: next_q.scratch_byte = q.scratch_byte;
      endcase
    end
    if (fifo_mode_i)
    begin
      // External FIFO must report not-empty in the same cycle as the push
      next_q.tx_hold_empty_flag = ~thr_wr & tx_fifo_empty_i; // [R3]
      next_q.tx_push = thr_wr;
    end
    else if (thr_wr)
      next_q.tx_hold_empty_flag = 1'b0; // [R2]
    else if (tx_take_i)
      next_q.tx_hold_empty_flag = 1'b1; // [R1]
    // New errors win over a line status read in the same cycle [R7]
    if (!fifo_mode_i)
      next_q.fifo_err = 1'b0; // [R6]
    else
      next_q.fifo_err = rx_fifo_has_error_i | (q.fifo_err & ~lsr_rd);
    next_q.host_rdata = host_rd_i ? read_mux(host_addr_i) : RST_BYTE;
    next_q.ec_rdata = ec_rd_i ? read_mux(ec_addr_i) : RST_BYTE; // [R20]
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.tx_hold_empty_flag <= 1'b1;
      q.modem_control_register <= RST_MCR;
    end
    else
      q <= next_q;
  end

  usm_modem_status u_modem_status (
    .clk_sys_i(clk_sys_i),
    .nrst_i(rst_n),
    .loopback_i(q.modem_control_register[MCR_LOOP]),
    .mcr_i(q.modem_control_register[MCR_AUX_OUTPUT_TWO:MCR_DTR]),
    .status_read_i(msr_rd),
    .msr_o(msr_val)
  );

  usm_baud_gen u_baud_gen (
    .clk_sys_i(clk_sys_i),
    .nrst_i(rst_n),
    .src_slow_i(src_slow_i),
    .src_fast_i(src_fast_i),
    .src_ext_i(src_ext_i),
    .ext_source_i(external_clock_source_i),
    .clock_select_i(q.div_hi[DIVH_CLKSEL]),
    .divisor_i(divisor),
    .reload_i(div_wr),
    .baud16_o(baud16_o)
  );

  assign host_rdata_o = q.host_rdata;
  assign ec_rdata_o = q.ec_rdata;
  assign tx_holding_register_o = q.tx_holding_register;
  assign tx_hold_valid_o = ~q.tx_hold_empty_flag & ~fifo_mode_i;
  assign tx_push_o = q.tx_push;
  assign tx_hold_empty_flag_o = q.tx_hold_empty_flag;
  assign tx_all_empty_flag_o = tx_all_empty_flag;
  assign tx_hold_empty_flag_irq_o = q.tx_hold_empty_flag & q.ier_tx_hold_empty_flag; // [R4]
  // Any delta bit raises the request while it is enabled [R11]
  assign modem_irq_o = (|msr_val[MS_DCD:MS_CTS]) & q.ier_ms;
  assign loopback_o = q.modem_control_register[MCR_LOOP];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  a_tx_hold_empty_flag_write_clear: assert property (thr_wr |=> !q.tx_hold_empty_flag) // [R2]
    else $error("holding write did not clear empty flag");
  a_tx_hold_empty_flag_take_set: assert property (!fifo_mode_i && tx_take_i
      && !thr_wr |=> q.tx_hold_empty_flag) // [R1]
    else $error("take did not set holding empty flag");
  a_tx_hold_empty_flag_fifo_follow: assert property (fifo_mode_i && !thr_wr
      |=> q.tx_hold_empty_flag == $past(tx_fifo_empty_i)) // [R3]
    else $error("fifo mode holding flag not tracking fifo");
  a_tx_hold_empty_flag_irq_gate: assert property (tx_hold_empty_flag_irq_o
      |-> q.ier_tx_hold_empty_flag && lsr_val[LSR_TX_HOLD_EMPTY_FLAG]) // [R4]
    else $error("holding interrupt without enable");
  a_tx_all_empty_flag_both: assert property (tx_all_empty_flag_o
      == (q.tx_hold_empty_flag && !tx_shift_busy_i)) // [R5]
    else $error("transmitter empty flag wrong");
  a_ferr_legacy_zero: assert property (!fifo_mode_i
      |=> !q.fifo_err) // [R6]
    else $error("fifo error set outside fifo mode");
  a_ferr_sticky: assert property (fifo_mode_i && q.fifo_err && !lsr_rd
      ##0 fifo_mode_i[*1] |=> q.fifo_err) // [R7]
    else $error("fifo error dropped without read");
  a_modem_irq: assert property (q.ier_ms && msr_val[MS_CTS]
      |-> modem_irq_o) // [R11]
    else $error("modem change without interrupt");
  a_scratch_hold: assert property (wr && waddr == OFS_SCR
      |=> q.scratch_byte == $past(wdata)) // [R15]
    else $error("scratch write lost");
  a_read_latency: assert property (host_rd_i && host_addr_i == OFS_SCR
      && !wr |=> host_rdata_o == $past(q.scratch_byte)) // [R20]
    else $error("host read data wrong");

  a_host_rd_idle: assert property (!host_rd_i // [R20]
      |=> host_rdata_o == RST_BYTE)
    else $error("host read data not idle");
  a_ec_rd_idle: assert property (!ec_rd_i // [R20]
      |=> ec_rdata_o == RST_BYTE)
    else $error("controller read data not idle");
  a_ec_read_data: assert property (ec_rd_i && ec_addr_i == OFS_SCR // [R20]
      && !wr |=> ec_rdata_o == $past(q.scratch_byte))
    else $error("controller read data wrong");
  a_push_on_write: assert property (fifo_mode_i // [R3]
      && thr_wr |=> tx_push_o)
    else $error("fifo push missing");
  a_push_only_write: assert property (!thr_wr // [R3]
      |=> !tx_push_o)
    else $error("fifo push without write");
  a_div_lo_write: assert property (div_wr // [R16]
      && waddr == OFS_DATA |=> q.div_lo == $past(wdata))
    else $error("divisor low byte not stored");
  a_div_hi_write: assert property (div_wr // [R16]
      && waddr == OFS_IER |=> q.div_hi == $past(wdata))
    else $error("divisor high byte not stored");
  a_div_no_hold: assert property (wr && q.divisor_access_bit // [R16]
      && waddr == OFS_DATA |=> q.tx_holding_register == $past(q.tx_holding_register))
    else $error("divisor write reached holding register");
  a_tx_hold_empty_flag_irq_on: assert property (q.tx_hold_empty_flag // [R4]
      && q.ier_tx_hold_empty_flag |-> tx_hold_empty_flag_irq_o)
    else $error("holding interrupt missing");
  a_modem_irq_off: assert property (!q.ier_ms // [R11]
      |-> !modem_irq_o)
    else $error("modem interrupt while disabled");
  a_ferr_set: assert property (fifo_mode_i // [R7]
      && rx_fifo_has_error_i |=> q.fifo_err)
    else $error("fifo error not set");
  a_ferr_read_clear: assert property (fifo_mode_i && lsr_rd // [R7]
      && !rx_fifo_has_error_i |=> !q.fifo_err)
    else $error("fifo error not cleared by read");
  a_tx_all_empty_flag_busy: assert property (tx_shift_busy_i // [R5]
      |-> !tx_all_empty_flag_o)
    else $error("transmitter empty while shifting");
  a_tx_all_empty_flag_hold_full: assert property (!q.tx_hold_empty_flag // [R5]
      |-> !tx_all_empty_flag_o)
    else $error("transmitter empty while holding full");
  a_scratch_other: assert property (wr // [R15]
      && waddr != OFS_SCR |=> q.scratch_byte == $past(q.scratch_byte))
    else $error("scratch changed by other write");
  a_modem_irq_dcd: assert property (q.ier_ms // [R11]
      && msr_val[MS_DCD] |-> modem_irq_o)
    else $error("carrier change without interrupt");
  a_modem_irq_dsr: assert property (q.ier_ms // [R11]
      && msr_val[MS_DSR] |-> modem_irq_o)
    else $error("data set change without interrupt");
  a_modem_irq_ri: assert property (q.ier_ms // [R11]
      && msr_val[MS_RI] |-> modem_irq_o)
    else $error("ring edge without interrupt");
  a_mcr_write: assert property (wr && waddr == OFS_MCR // [R13]
      |=> q.modem_control_register == $past(wdata[MCR_LOOP:0]))
    else $error("modem control not stored");
  a_divisor_access_bit_write: assert property (wr && waddr == OFS_LCR // [R19]
      |=> q.divisor_access_bit == $past(wdata[LCR_DIVISOR_ACCESS_BIT]))
    else $error("divisor access bit not stored");
  a_ec_wins: assert property (ec_wr_i // [R20]
      |-> waddr == ec_addr_i && wdata == ec_wdata_i)
    else $error("controller write lost to host");
  a_hold_data: assert property (thr_wr // [R2]
      |=> tx_holding_register_o == $past(wdata))
    else $error("holding data not stored");

  c_tx_hold_empty_flag_cycle: cover property (thr_wr ##[1:50] q.tx_hold_empty_flag);
  c_modem_loop: cover property (q.modem_control_register[MCR_LOOP] ##1 modem_irq_o);
  c_div_reload: cover property (div_wr ##1 div_wr);
  c_ferr_clear: cover property (q.fifo_err ##1 !q.fifo_err);
  c_ec_read: cover property (ec_rd_i ##1 ec_rdata_o != RST_BYTE);
endmodule : usm_status_regs

//--- verilog/usm_pkg.sv
// Register map, field positions and constants of the serial port status block
package usm_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_FCR = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  localparam int unsigned LSR_TX_HOLD_EMPTY_FLAG = 5;
  localparam int unsigned LSR_TX_ALL_EMPTY_FLAG = 6;
  localparam int unsigned LSR_FERR = 7;
  localparam int unsigned LCR_DIVISOR_ACCESS_BIT = 7;
  localparam int unsigned IER_TX_HOLD_EMPTY_FLAG = 1;
  localparam int unsigned IER_MS = 3;
  localparam int unsigned MCR_DTR = 0;
  localparam int unsigned MCR_RTS = 1;
  localparam int unsigned MCR_AUX_OUTPUT_ONE = 2;
  localparam int unsigned MCR_AUX_OUTPUT_TWO = 3;
  localparam int unsigned MCR_LOOP = 4;
  localparam int unsigned DIVH_CLKSEL = 7;
  localparam int unsigned MS_CTS = 0;
  localparam int unsigned MS_DSR = 1;
  localparam int unsigned MS_RI = 2;
  localparam int unsigned MS_DCD = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_MCR = 5'h00;
  localparam logic [3:0] MS_IDLE = 4'h0;
  localparam logic [15:0] DIV_ZERO = 16'h0000;
  localparam logic [15:0] DIV_INV = 16'h0001;
  localparam logic [15:0] DIV_HALF = 16'h0002;
  localparam logic [15:0] DIV_ZERO_AS = 16'h0003;
  localparam logic [15:0] DIV_LOW_COUNTS = 16'h0002;
  localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage : usm_pkg

//--- verilog/usm_baud_gen.sv
// Programmable 16x baud clock generator with source select and reload
`timescale 1ns/100ps
module usm_baud_gen
  import usm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic src_slow_i,
  input wire logic src_fast_i,
  input wire logic src_ext_i,
  input wire logic ext_source_i,
  input wire logic clock_select_i,
  input wire logic [15:0] divisor_i,
  input wire logic reload_i,
  output logic baud16_o
);
  typedef struct packed {
    logic src;
    logic [15:0] cnt;
    logic out;
  } usm_baud_s;
  usm_baud_s q;
  usm_baud_s next_q;
  logic src;
  logic rise;
  logic [15:0] span;
  logic [15:0] cnt_inc;

  always_comb
  begin
    // With the external source chosen the select bit is ignored [R18]
    src = ext_source_i ? src_ext_i : (clock_select_i ? src_fast_i : src_slow_i);
    rise = src & ~q.src;
    span = (divisor_i == DIV_ZERO) ? DIV_ZERO_AS : divisor_i; // [R17]
    cnt_inc = q.cnt + CNT_ONE;
    next_q = q;
    next_q.src = src;
    if (reload_i)
    begin
      // Restart at once so a fresh divisor never waits out an old count
      next_q.cnt = DIV_ZERO; // [R16]
      next_q.out = 1'b0;
    end
    else if (divisor_i == DIV_INV)
      next_q.out = ~src; // [R17]
    else if (rise && divisor_i == DIV_HALF)
      next_q.out = ~q.out; // [R17]
    else if (rise)
    begin
      next_q.cnt = (cnt_inc >= span) ? DIV_ZERO : cnt_inc;
      next_q.out = (next_q.cnt >= DIV_LOW_COUNTS); // [R17]
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '0;
    else
      q <= next_q;
  end

  assign baud16_o = q.out;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_reload_restarts: assert property (reload_i |=> q.cnt == DIV_ZERO) // [R16]
    else $error("baud counter not reloaded on divisor write");
  a_half_toggles: assert property (!reload_i && rise
      && divisor_i == DIV_HALF |=> q.out != $past(q.out)) // [R17]
    else $error("divide by two output failed to toggle");
endmodule : usm_baud_gen

//--- verilog/usm_modem_status.sv
// Modem status current state and change flags with loopback mapping
`timescale 1ns/100ps
module usm_modem_status
  import usm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic loopback_i,
  input wire logic [3:0] mcr_i,
  input wire logic status_read_i,
  output logic [7:0] msr_o
);
  typedef struct packed {
    logic [3:0] cur;
    logic [3:0] delta;
  } usm_msr_s;
  usm_msr_s q;
  usm_msr_s next_q;
  logic [3:0] set;

  always_comb
  begin
    next_q = q;
    // No modem pins exist, so outside loopback the lines sit idle [R14]
    next_q.cur = MS_IDLE; // [R12]
    if (loopback_i)
    begin
      next_q.cur[MS_CTS] = mcr_i[MCR_RTS]; // [R13]
      next_q.cur[MS_DSR] = mcr_i[MCR_DTR]; // [R13]
      next_q.cur[MS_RI] = mcr_i[MCR_AUX_OUTPUT_ONE]; // [R13]
      next_q.cur[MS_DCD] = mcr_i[MCR_AUX_OUTPUT_TWO]; // [R13]
    end
    set = next_q.cur ^ q.cur; // [R8]
    // Ring flags only when the pin level returns high [R9]
    set[MS_RI] = q.cur[MS_RI] & ~next_q.cur[MS_RI];
    // A change in the read cycle survives the clear [R10]
    next_q.delta = (status_read_i ? MS_IDLE : q.delta) | set;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '0;
    else
      q <= next_q;
  end

  assign msr_o = {q.cur, q.delta};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_read_clears: assert property (status_read_i
      && next_q.cur == q.cur |=> q.delta == MS_IDLE) // [R10]
    else $error("change bits not cleared by status read");
  a_ring_rise_only: assert property (!q.delta[MS_RI] // [R9]
      ##1 q.delta[MS_RI] |-> $past(q.cur[MS_RI]) && !q.cur[MS_RI])
    else $error("ring flag set without trailing edge");
  a_loop_map: assert property (loopback_i |=> q.cur[MS_CTS] // [R13]
      == $past(mcr_i[MCR_RTS]) && q.cur[MS_DCD] == $past(mcr_i[MCR_AUX_OUTPUT_TWO]))
    else $error("loopback mapping wrong");
endmodule : usm_modem_status

//--- dv/usm_far_model.sv
// Far-side model: serializer, transmit FIFO and baud source clocks
`timescale 1ns/100ps
module usm_far_model
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic stall_i,
  input wire logic tx_hold_valid_i,
  input wire logic tx_push_i,
  output logic tx_take_o,
  output logic tx_shift_busy_o,
  output logic tx_fifo_empty_o,
  output logic src_slow_o,
  output logic src_fast_o,
  output logic src_ext_o
);
  logic [3:0] busy;
  logic [4:0] div;
  logic empty;
  // A push hides the empty level at once, so no stale empty is seen
  assign tx_fifo_empty_o = empty & !tx_push_i;
  assign tx_shift_busy_o = busy != 4'h0;
  assign src_slow_o = div[4];
  assign src_fast_o = div[1];
  assign src_ext_o = div[2];
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      busy <= 4'h0;
      div <= 5'h00;
      empty <= 1'b1;
      tx_take_o <= 1'b0;
    end
    else
    begin
      div <= div + 5'h01;
      tx_take_o <= 1'b0;
      if (busy != 4'h0)
        busy <= busy - 4'h1;
      if (tx_push_i)
        empty <= 1'b0;
      else if (busy == 4'h0 && !stall_i && !empty)
      begin
        empty <= 1'b1;
        busy <= 4'h8;
      end
      else if (busy == 4'h0 && !stall_i && tx_hold_valid_i && !tx_take_o)
      begin
        tx_take_o <= 1'b1;
        busy <= 4'h8;
      end
    end
  end
endmodule : usm_far_model

//--- dv/tb_uart_status_modem_baud_regs.sv
// Self-checking bench of the serial port status register block
`timescale 1ns/100ps
module tb_uart_status_modem_baud_regs;
  import usm_pkg::*;
  logic clk_sys_i = 0, nrst_i = 0, nsio_rst_i = 1, power_vcc_i = 0;
  logic [2:0] host_addr_i = 0, ec_addr_i = 0;
  logic [7:0] host_wdata_i = 0, ec_wdata_i = 0, d;
  logic [7:0] host_rdata_o, ec_rdata_o, tx_holding_register_o;
  logic host_wr_i = 0, host_rd_i = 0, ec_wr_i = 0, ec_rd_i = 0, stall = 1;
  logic fifo_mode_i = 0, rx_fifo_has_error_i = 0;
  logic external_clock_source_i = 0;
  logic tx_take_i, tx_shift_busy_i, tx_fifo_empty_i;
  logic src_slow_i, src_fast_i, src_ext_i, tx_hold_valid_o, tx_push_o;
  logic tx_hold_empty_flag_o, tx_all_empty_flag_o, tx_hold_empty_flag_irq_o;
  logic modem_irq_o, loopback_o, baud16_o;
  int err_count = 0, checks_done = 0;

  usm_status_regs uut (.clk_sys_i, .nrst_i, .nsio_rst_i, .power_vcc_i,
    .host_addr_i, .host_wdata_i, .host_wr_i, .host_rd_i, .host_rdata_o,
    .ec_addr_i, .ec_wdata_i, .ec_wr_i, .ec_rd_i, .ec_rdata_o, .fifo_mode_i,
    .tx_take_i, .tx_shift_busy_i, .tx_fifo_empty_i, .rx_fifo_has_error_i,
    .external_clock_source_i, .src_slow_i, .src_fast_i, .src_ext_i,
    .tx_holding_register_o, .tx_hold_valid_o, .tx_push_o,
    .tx_hold_empty_flag_o, .tx_all_empty_flag_o, .tx_hold_empty_flag_irq_o, .modem_irq_o,
    .loopback_o, .baud16_o);
  usm_far_model far (.clk_sys_i, .nrst_i, .stall_i(stall),
    .tx_hold_valid_i(tx_hold_valid_o), .tx_push_i(tx_push_o),
    .tx_take_o(tx_take_i), .tx_shift_busy_o(tx_shift_busy_i),
    .tx_fifo_empty_o(tx_fifo_empty_i), .src_slow_o(src_slow_i),
    .src_fast_o(src_fast_i), .src_ext_o(src_ext_i));

  initial
  begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // Both ports share address and data; the strobe picks the port
  task automatic wr(input bit p, input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    host_addr_i <= a;
    ec_addr_i <= a;
    host_wdata_i <= v;
    ec_wdata_i <= v;
    host_wr_i <= !p;
    ec_wr_i <= p;
    @(posedge clk_sys_i);
    host_wr_i <= 1'b0;
    ec_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input bit p, input logic [2:0] a);
    @(posedge clk_sys_i);
    host_addr_i <= a;
    ec_addr_i <= a;
    host_rd_i <= !p;
    ec_rd_i <= p;
    @(posedge clk_sys_i);
    host_rd_i <= 1'b0;
    ec_rd_i <= 1'b0;
    #1;
    d = p ? ec_rdata_o : host_rdata_o;
  endtask : rd

  task automatic wait_flag(input string m);
    int n;
    n = 0;
    while (tx_hold_empty_flag_o !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk({7'h00, tx_hold_empty_flag_o}, 8'h01, m);
  endtask : wait_flag

  task automatic t_reset;
    rd(0, OFS_LSR);
    chk(d, 8'h60, "lsr reset");
    rd(1, OFS_MSR);
    chk(d & 8'h0f, 8'h00, "msr reset");
    wr(0, OFS_SCR, 8'ha5);
    rd(1, OFS_SCR);
    chk(d, 8'ha5, "scratch ec");
    wr(1, OFS_LSR, 8'h00);
    rd(0, OFS_LSR);
    chk(d, 8'h60, "lsr read only");
    @(posedge clk_sys_i);
    power_vcc_i <= 1'b1;
    nsio_rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nsio_rst_i <= 1'b1;
    rd(0, OFS_SCR);
    chk(d, 8'h00, "io reset");
  endtask : t_reset

  task automatic t_tx_plain;
    wr(0, OFS_IER, 8'h02);
    chk({7'h00, tx_hold_empty_flag_irq_o}, 8'h01, "irq on");
    wr(0, OFS_DATA, 8'h3c);
    chk({7'h00, tx_hold_empty_flag_o}, 8'h00, "hold full");
    chk({7'h00, tx_hold_valid_o}, 8'h01, "hold valid");
    chk({7'h00, tx_all_empty_flag_o}, 8'h00, "not empty");
    chk({7'h00, tx_hold_empty_flag_irq_o}, 8'h00, "irq off");
    chk(tx_holding_register_o, 8'h3c, "hold data");
    @(posedge clk_sys_i);
    stall <= 1'b0;
    wait_flag("taken");
    chk({7'h00, tx_hold_empty_flag_irq_o}, 8'h01, "irq back");
    chk({7'h00, tx_all_empty_flag_o}, 8'h00, "shifting");
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk({7'h00, tx_all_empty_flag_o}, 8'h01, "all empty");
    wr(1, OFS_IER, 8'h00);
    chk({7'h00, tx_hold_empty_flag_irq_o}, 8'h00, "masked");
  endtask : t_tx_plain

  task automatic t_tx_fifo;
    stall <= 1'b1;
    fifo_mode_i <= 1'b1;
    wr(0, OFS_DATA, 8'hc3);
    chk({7'h00, tx_push_o}, 8'h01, "push");
    chk(tx_holding_register_o, 8'hc3, "push data");
    @(posedge clk_sys_i);
    #1;
    chk({7'h00, tx_hold_empty_flag_o}, 8'h00, "fifo full");
    stall <= 1'b0;
    wait_flag("fifo drained");
    rx_fifo_has_error_i <= 1'b1;
    rd(0, OFS_LSR);
    chk(d & 8'h80, 8'h80, "ferr set");
    @(posedge clk_sys_i);
    rx_fifo_has_error_i <= 1'b0;
    rd(1, OFS_LSR);
    chk(d & 8'h80, 8'h80, "ferr sticky");
    rd(0, OFS_LSR);
    chk(d & 8'h80, 8'h00, "ferr cleared");
    fifo_mode_i <= 1'b0;
    rx_fifo_has_error_i <= 1'b1;
    rd(0, OFS_LSR);
    chk(d & 8'h80, 8'h00, "ferr plain");
    rx_fifo_has_error_i <= 1'b0;
  endtask : t_tx_fifo

  task automatic t_modem;
    wr(0, OFS_IER, 8'h08);
    wr(0, OFS_MCR, 8'h10);
    chk({7'h00, loopback_o}, 8'h01, "loop on");
    rd(0, OFS_MSR);
    chk(d, 8'h00, "loop idle");
    wr(1, OFS_MCR, 8'h1f);
    // Status bits follow the control register one cycle later
    @(posedge clk_sys_i);
    #1;
    chk({7'h00, modem_irq_o}, 8'h01, "ms irq");
    rd(0, OFS_MSR);
    chk(d, 8'hfb, "deltas");
    rd(1, OFS_MSR);
    chk(d, 8'hf0, "read clear");
    chk({7'h00, modem_irq_o}, 8'h00, "irq clear");
    wr(0, OFS_MCR, 8'h13);
    rd(1, OFS_MSR);
    chk(d, 8'h3c, "ring trail");
    rd(0, OFS_MSR);
    chk(d, 8'h30, "cleared");
    wr(0, OFS_MCR, 8'h17);
    rd(0, OFS_MSR);
    chk(d, 8'h70, "ring rise");
    wr(0, OFS_MCR, 8'h03);
    rd(0, OFS_MSR);
    chk(d & 8'hf0, 8'h00, "no pins");
  endtask : t_modem

  task automatic baud(input logic x, input logic [7:0] h, input logic [7:0] l,
    input int er, input int eh);
    int r, hc;
    logic p;
    @(posedge clk_sys_i);
    external_clock_source_i <= x;
    wr(0, OFS_LCR, 8'h80);
    wr(0, OFS_DATA, l);
    wr(1, OFS_IER, h);
    chk({7'h00, baud16_o}, 8'h00, "reload");
    rd(0, OFS_IER);
    chk(d, h, "div high");
    rd(1, OFS_DATA);
    chk(d, l, "div low");
    r = 0;
    hc = 0;
    p = baud16_o;
    repeat (768)
    begin
      @(posedge clk_sys_i);
      #1;
      if (baud16_o === 1'b1 && p === 1'b0)
        r++;
      if (baud16_o === 1'b1)
        hc++;
      p = baud16_o;
    end
    checks_done++;
    if (r < er - 1 || r > er + 1 || hc < eh - 24 || hc > eh + 24)
    begin
      err_count++;
      $display("[FAIL] %0t baud %h%h rises %0d high %0d", $time, h, l, r, hc);
    end
  endtask : baud

  task automatic t_baud;
    baud(1'b0, 8'h00, 8'h01, 24, 384);
    baud(1'b0, 8'h00, 8'h02, 12, 384);
    baud(1'b0, 8'h00, 8'h00, 8, 256);
    baud(1'b0, 8'h80, 8'h08, 24, 576);
    baud(1'b1, 8'h80, 8'h04, 24, 384);
    baud(1'b1, 8'h00, 8'h04, 24, 384);
  endtask : t_baud

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_reset;
    t_tx_plain;
    t_tx_fifo;
    t_modem;
    t_baud;
    end_of_test;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule : tb_uart_status_modem_baud_regs
